// File: include/dbgcs_pkg.sv
// constants and types shared by the debugger control and status block
// Functional notes
// - write 81H: reset device, stay halted
// - write 41H: reset device, run, breaks on
// - write 40H while halted: resume, breaks on
// - bit 7 set halts instruction fetch
// - bit 7 clear resumes fetch unless locked
// - enabled break, no spin: sets bit 7
// - read lock: zero write to bit 7 ignored
// - bit 6 resets clear; break is no-op
// - bit 5: send FFH on breakpoint
// - bit 4 picks halt or spin on break
// - bit 0 resets device, not debugger
// - bit 0 self-clears when reset completes
// - idle: halted or break since write
// - status bit 6 mirrors low-power halt
// - status bit 5: set while read lock active
// - 04H writes control, 05H reads it
// - 02H returns one status byte
package dbgcs_pkg;
	// link command bytes
	localparam logic [7:0] DBGCS_CMD_RD_STAT = 8'h02;
	localparam logic [7:0] DBGCS_CMD_WR_CTL = 8'h04;
	localparam logic [7:0] DBGCS_CMD_RD_CTL = 8'h05;
	// opcodes and characters
	localparam logic [7:0] DBGCS_BREAK_OPCODE = 8'h00;
	localparam logic [7:0] DBGCS_ACK_CHAR = 8'hff;
	// control register fields
	localparam int DBGCS_CTL_HALT_BIT = 7;
	localparam int DBGCS_CTL_BREAK_OPCODE_ENABLE_BIT = 6;
	localparam int DBGCS_CTL_ACK_BIT = 5;
	localparam int DBGCS_CTL_SPIN_BIT = 4;
	localparam int DBGCS_CTL_RST_BIT = 0;
	localparam logic [7:0] DBGCS_CTL_RESET = 8'h00;
	localparam logic [7:0] DBGCS_CTL_WMASK = 8'hf1;
	// status register fields
	localparam int DBGCS_STAT_IDLE_BIT = 7;
	localparam int DBGCS_STAT_HALT_BIT = 6;
	localparam int DBGCS_STAT_LOCK_BIT = 5;
	localparam logic [4:0] DBGCS_STAT_RSVD = 5'h00;
	// timing of the self-triggered reset pulse
	localparam int DBGCS_CLK_PERIOD_NS = 10;
	localparam int DBGCS_SELF_RST_NS = 1000;
	localparam int DBGCS_SELF_RST_CYC = (DBGCS_SELF_RST_NS + DBGCS_CLK_PERIOD_NS - 1) / DBGCS_CLK_PERIOD_NS;
	// command parser states
	typedef enum logic {DBGCS_PS_CMD, DBGCS_PS_WDATA} dbgcs_parse_t;
	// self reset sequencer states
	typedef enum logic [1:0] {DBGCS_RS_IDLE, DBGCS_RS_ACTIVE, DBGCS_RS_FINISH} dbgcs_rseq_t;
endpackage

// File: hw/dbgcs_reset_seq.sv
// self reset sequencer: drives the device reset while the debugger keeps running
`timescale 1ns/10ps
`default_nettype none
module dbgcs_reset_seq import dbgcs_pkg::*; #(
	parameter int RESET_CYCLES = DBGCS_SELF_RST_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	output logic o_sys_rst_n,
	output logic o_done
);
	dbgcs_rseq_t state_reg, state_next;
	logic [15:0] cnt_reg, cnt_next;
	logic sys_rst_n_reg, sys_rst_n_next;
	logic done_reg, done_next;

	// sequence: hold reset low for the count, then report completion once
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		sys_rst_n_next = sys_rst_n_reg;
		done_next = 1'b0;
		case (state_reg)
			DBGCS_RS_IDLE: begin
				if (i_start) begin
					state_next = DBGCS_RS_ACTIVE;
					cnt_next = 16'(RESET_CYCLES - 1);
					sys_rst_n_next = 1'b0;
				end
			end
			DBGCS_RS_ACTIVE: begin
				if (cnt_reg == 16'h0000) begin
					state_next = DBGCS_RS_FINISH;
					sys_rst_n_next = 1'b1;
					done_next = 1'b1;
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
			default: begin
				// rearm next cycle: the done pulse has cleared the request bit by then,
				// unless a write in the done cycle set it again, which must run
				state_next = DBGCS_RS_IDLE;
			end
		endcase
	end

	// state registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= DBGCS_RS_IDLE;
			cnt_reg <= 16'h0000;
			sys_rst_n_reg <= 1'b1;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			sys_rst_n_reg <= sys_rst_n_next;
			done_reg <= done_next;
		end
	end

	assign o_sys_rst_n = sys_rst_n_reg;
	assign o_done = done_reg;
endmodule
`default_nettype wire

// File: hw/dbgcs_top.sv
// debugger control and status registers behind the serial debug link
`timescale 1ns/10ps
`default_nettype none
module dbgcs_top import dbgcs_pkg::*; #(
	parameter int RESET_CYCLES = DBGCS_SELF_RST_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_byte,
	input wire logic i_tx_ready,
	input wire logic i_opcode_valid,
	input wire logic [7:0] i_opcode,
	input wire logic i_halt_mode,
	input wire logic i_read_lock_opt_n,
	output logic o_tx_valid,
	output logic [7:0] o_tx_byte,
	output logic o_fetch_stall,
	output logic o_break_spin,
	output logic o_break_nop,
	output logic o_sys_rst_n
);
	dbgcs_parse_t parse_reg, parse_next;
	logic [7:0] ctl_reg, ctl_next;
	logic seen_reg, seen_next;
	logic ack_pend_reg, ack_pend_next;
	logic tx_valid_reg, tx_valid_next;
	logic [7:0] tx_byte_reg, tx_byte_next;
	logic spin_reg, spin_next;
	logic nop_reg, nop_next;
	logic wr_ctl, is_break, brk_hit, ack_evt, read_lock, tx_free;
	logic resp_req, rst_done;
	logic [7:0] resp_byte, wr_val, stat_val;

	// decoded events of this cycle
	always_comb begin
		read_lock = !i_read_lock_opt_n;
		wr_ctl = i_rx_valid && (parse_reg == DBGCS_PS_WDATA);
		is_break = i_opcode_valid && (i_opcode == DBGCS_BREAK_OPCODE);
		brk_hit = is_break && ctl_reg[DBGCS_CTL_BREAK_OPCODE_ENABLE_BIT];
		ack_evt = brk_hit && ctl_reg[DBGCS_CTL_ACK_BIT];
		tx_free = !tx_valid_reg || i_tx_ready;
	end

	// live status byte, reserved field forced to zero
	always_comb begin
		stat_val = {ctl_reg[DBGCS_CTL_HALT_BIT] || seen_reg, i_halt_mode, read_lock, DBGCS_STAT_RSVD};
	end

	// command parser: read commands answer at once, write takes one data byte
	always_comb begin
		parse_next = parse_reg;
		resp_req = 1'b0;
		resp_byte = ctl_reg;
		if (i_rx_valid) begin
			if (parse_reg == DBGCS_PS_WDATA) begin
				parse_next = DBGCS_PS_CMD;
			end else if (i_rx_byte == DBGCS_CMD_WR_CTL) begin
				parse_next = DBGCS_PS_WDATA;
			end else if (i_rx_byte == DBGCS_CMD_RD_CTL) begin
				resp_req = 1'b1;
				resp_byte = ctl_reg;
			end else if (i_rx_byte == DBGCS_CMD_RD_STAT) begin
				resp_req = 1'b1;
				resp_byte = stat_val;
			end
		end
	end

	// control register next value
	always_comb begin
		wr_val = i_rx_byte & DBGCS_CTL_WMASK;
		ctl_next = ctl_reg;
		if (rst_done) begin
			ctl_next[DBGCS_CTL_RST_BIT] = 1'b0;
		end
		if (wr_ctl) begin
			// a pending self reset is not cancelled by a later write
			wr_val[DBGCS_CTL_RST_BIT] = wr_val[DBGCS_CTL_RST_BIT] || ctl_next[DBGCS_CTL_RST_BIT];
			if (read_lock) begin
				wr_val[DBGCS_CTL_HALT_BIT] = wr_val[DBGCS_CTL_HALT_BIT] || ctl_reg[DBGCS_CTL_HALT_BIT];
			end
			ctl_next = wr_val;
		end
		if (brk_hit && !ctl_reg[DBGCS_CTL_SPIN_BIT]) begin
			ctl_next[DBGCS_CTL_HALT_BIT] = 1'b1;
		end
	end

	// break bookkeeping: sticky seen flag, spin and no-op pulses
	always_comb begin
		seen_next = seen_reg;
		if (wr_ctl) begin
			seen_next = 1'b0;
		end
		if (brk_hit) begin
			seen_next = 1'b1;
		end
		spin_next = brk_hit && ctl_reg[DBGCS_CTL_SPIN_BIT];
		nop_next = is_break && !ctl_reg[DBGCS_CTL_BREAK_OPCODE_ENABLE_BIT];
	end

	// transmit holding register: answers first, then acknowledge char
	always_comb begin
		tx_valid_next = tx_valid_reg;
		tx_byte_next = tx_byte_reg;
		ack_pend_next = ack_pend_reg;
		if (tx_free) begin
			tx_valid_next = 1'b0;
			if (resp_req) begin
				tx_valid_next = 1'b1;
				tx_byte_next = resp_byte;
			end else if (ack_pend_reg) begin
				tx_valid_next = 1'b1;
				tx_byte_next = DBGCS_ACK_CHAR;
				ack_pend_next = 1'b0;
			end
		end
		if (ack_evt) begin
			ack_pend_next = 1'b1;
		end
	end

	// registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			parse_reg <= DBGCS_PS_CMD;
			ctl_reg <= DBGCS_CTL_RESET;
			seen_reg <= 1'b0;
			ack_pend_reg <= 1'b0;
			tx_valid_reg <= 1'b0;
			tx_byte_reg <= 8'h00;
			spin_reg <= 1'b0;
			nop_reg <= 1'b0;
		end else begin
			parse_reg <= parse_next;
			ctl_reg <= ctl_next;
			seen_reg <= seen_next;
			ack_pend_reg <= ack_pend_next;
			tx_valid_reg <= tx_valid_next;
			tx_byte_reg <= tx_byte_next;
			spin_reg <= spin_next;
			nop_reg <= nop_next;
		end
	end

	// device reset pulse generator
	dbgcs_reset_seq #(
		.RESET_CYCLES(RESET_CYCLES)
	) u_reset_seq (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_start(ctl_reg[DBGCS_CTL_RST_BIT]),
		.o_sys_rst_n(o_sys_rst_n),
		.o_done(rst_done)
	);

	// outputs straight from flops
	assign o_tx_valid = tx_valid_reg;
	assign o_tx_byte = tx_byte_reg;
	assign o_fetch_stall = ctl_reg[DBGCS_CTL_HALT_BIT];
	assign o_break_spin = spin_reg;
	assign o_break_nop = nop_reg;

	// helper for the checks: cycles of the current device reset pulse
	logic [15:0] low_cnt_reg, low_cnt_next;
	always_comb begin
		low_cnt_next = 16'h0000;
		if (!o_sys_rst_n) begin
			low_cnt_next = low_cnt_reg + 16'h0001;
		end
	end

	// helper counter register
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			low_cnt_reg <= 16'h0000;
		end else begin
			low_cnt_reg <= low_cnt_next;
		end
	end

	// checks on the block's own behaviour
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	chk_stop_write_halts: assert property (
		wr_ctl && i_rx_byte == 8'h81 |=> o_fetch_stall && ctl_reg[DBGCS_CTL_RST_BIT] ##1 !o_sys_rst_n)
		else $error("81H write did not halt and start reset");

	chk_go_write_runs: assert property (
		wr_ctl && i_rx_byte == 8'h41 && !read_lock && !brk_hit && !rst_done
		|=> !o_fetch_stall && ctl_reg[DBGCS_CTL_BREAK_OPCODE_ENABLE_BIT] && ctl_reg[DBGCS_CTL_RST_BIT])
		else $error("41H write did not reset and run");

	chk_run_resumes: assert property (
		o_fetch_stall && wr_ctl && i_rx_byte == 8'h40 && !read_lock && !brk_hit
		|=> !o_fetch_stall && ctl_reg[DBGCS_CTL_BREAK_OPCODE_ENABLE_BIT])
		else $error("40H write did not resume");

	chk_lock_keeps_halt: assert property (
		read_lock && o_fetch_stall |=> o_fetch_stall)
		else $error("halt cleared under read lock");

	chk_break_halts: assert property (
		brk_hit && !ctl_reg[DBGCS_CTL_SPIN_BIT] |=> o_fetch_stall && stat_val[DBGCS_STAT_IDLE_BIT])
		else $error("enabled break did not halt");

	chk_break_spins: assert property (
		brk_hit && ctl_reg[DBGCS_CTL_SPIN_BIT] && !wr_ctl |=> o_break_spin && $stable(o_fetch_stall))
		else $error("spin break did not spin");

	chk_break_nop: assert property (
		is_break && !ctl_reg[DBGCS_CTL_BREAK_OPCODE_ENABLE_BIT] && !wr_ctl |=> o_break_nop && !o_break_spin && $stable(seen_reg))
		else $error("disabled break not a no-op");

	chk_ack_queued: assert property (
		ack_evt |=> ack_pend_reg || (o_tx_valid && o_tx_byte == DBGCS_ACK_CHAR))
		else $error("acknowledge char lost");

	chk_reset_start: assert property (
		$rose(ctl_reg[DBGCS_CTL_RST_BIT]) |=> !o_sys_rst_n [*3])
		else $error("self reset pulse missing");

	chk_reset_clears: assert property (
		rst_done && !wr_ctl |=> !ctl_reg[DBGCS_CTL_RST_BIT])
		else $error("reset bit did not self clear");

	chk_status_read: assert property (
		resp_req && tx_free && i_rx_byte == DBGCS_CMD_RD_STAT
		|=> o_tx_valid && o_tx_byte[DBGCS_STAT_LOCK_BIT] == !$past(i_read_lock_opt_n)
		&& o_tx_byte[DBGCS_STAT_HALT_BIT] == $past(i_halt_mode) && o_tx_byte[4:0] == DBGCS_STAT_RSVD)
		else $error("status byte wrong");

	chk_ctl_reserved: assert property (
		ctl_reg[3:1] == 3'h0)
		else $error("reserved control bits set");

	// halt bit and break handling
	chk_halt_cause: assert property (
		!o_fetch_stall && !(wr_ctl && i_rx_byte[DBGCS_CTL_HALT_BIT])
		&& !(brk_hit && !ctl_reg[DBGCS_CTL_SPIN_BIT]) |=> !o_fetch_stall)
		else $error("halt set without cause");

	chk_unlocked_clear: assert property (
		wr_ctl && !i_rx_byte[DBGCS_CTL_HALT_BIT] && !read_lock && !brk_hit
		|=> !o_fetch_stall)
		else $error("unlocked zero write did not resume");

	chk_disabled_inert: assert property (
		is_break && !ctl_reg[DBGCS_CTL_BREAK_OPCODE_ENABLE_BIT] && !o_fetch_stall && !wr_ctl
		|=> !o_fetch_stall && !o_break_spin)
		else $error("disabled break had an effect");

	chk_write_clears_idle: assert property (
		wr_ctl && !i_rx_byte[DBGCS_CTL_HALT_BIT] && !read_lock && !brk_hit
		|=> !stat_val[DBGCS_STAT_IDLE_BIT])
		else $error("idle flag survived a control write");

	// acknowledge character
	chk_ack_idle: assert property (
		!ack_pend_reg && !ack_evt |=> !ack_pend_reg)
		else $error("acknowledge queued without a break");

	chk_ack_sent: assert property (
		ack_pend_reg && tx_free && !resp_req
		|=> o_tx_valid && o_tx_byte == DBGCS_ACK_CHAR)
		else $error("pending acknowledge not offered");

	chk_ack_behind_answer: assert property (
		ack_pend_reg && tx_free && resp_req |=> o_tx_valid && ack_pend_reg)
		else $error("acknowledge lost behind an answer");

	// self reset
	chk_reset_length: assert property (
		$rose(o_sys_rst_n) |-> low_cnt_reg == 16'(RESET_CYCLES))
		else $error("device reset pulse has wrong length");

	chk_done_with_bit: assert property (
		rst_done |-> ctl_reg[DBGCS_CTL_RST_BIT] && o_sys_rst_n)
		else $error("reset done without request bit");

	// link parser and transmit holding register
	chk_ctl_read_echo: assert property (
		resp_req && tx_free && i_rx_byte == DBGCS_CMD_RD_CTL
		|=> o_tx_valid && o_tx_byte == $past(ctl_reg))
		else $error("control read answer wrong");

	chk_parse_data: assert property (
		i_rx_valid && parse_reg == DBGCS_PS_CMD && i_rx_byte == DBGCS_CMD_WR_CTL
		|=> parse_reg == DBGCS_PS_WDATA)
		else $error("write command not followed by data state");

	chk_parse_back: assert property (
		wr_ctl |=> parse_reg == DBGCS_PS_CMD)
		else $error("parser stuck after data byte");

	chk_tx_stands: assert property (
		o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
		else $error("offered byte changed before taken");

	cov_break_halt: cover property (brk_hit && !ctl_reg[DBGCS_CTL_SPIN_BIT] ##1 o_fetch_stall);
	cov_spin_break: cover property (brk_hit && ctl_reg[DBGCS_CTL_SPIN_BIT] ##1 o_break_spin);
	cov_self_reset: cover property ($rose(ctl_reg[DBGCS_CTL_RST_BIT]) ##[1:200] rst_done);
	cov_ack_sent: cover property (ack_evt ##[1:20] (o_tx_valid && o_tx_byte == DBGCS_ACK_CHAR && i_tx_ready));
	cov_lock_write: cover property (read_lock && o_fetch_stall && wr_ctl && !i_rx_byte[DBGCS_CTL_HALT_BIT]);
endmodule
`default_nettype wire

// File: test/dbgcs_host_model.sv
// host side of the serial debug link: sends bytes, takes answers
`timescale 1ns/10ps
`default_nettype none
module dbgcs_host_model (
	input wire logic i_clk,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_byte,
	output logic o_rx_valid,
	output logic [7:0] o_rx_byte,
	output logic o_tx_ready
);
	int got_cnt = 0;
	logic [7:0] got = 8'h00;
	initial begin
		o_rx_valid = 1'b0;
		o_rx_byte = 8'h5a;
		o_tx_ready = 1'b1;
	end
	// one byte a cycle, back to back allowed
	task send(input logic [7:0] b);
		@(posedge i_clk);
		#1 o_rx_valid = 1'b1;
		o_rx_byte = b;
	endtask
	// released byte lines show the inverse, never the stale value
	task idle();
		@(posedge i_clk);
		#1 o_rx_valid = 1'b0;
		o_rx_byte = ~o_rx_byte;
	endtask
	// control write: command then one data byte
	task wr_ctl(input logic [7:0] v);
		send(8'h04);
		send(v);
		idle();
	endtask
	// slow host: hold off the transmitter
	task set_ready(input logic b);
		@(posedge i_clk);
		#1 o_tx_ready = b;
	endtask
	// collect answer bytes; whole byte kept, the bench checks reserved status bits as zero
	always @(posedge i_clk) begin
		if (i_tx_valid && o_tx_ready) begin
			got <= i_tx_byte;
			got_cnt <= got_cnt + 1;
		end
	end
endmodule
`default_nettype wire

// File: test/dbgcs_top_tb.sv
// self-checking bench for the debugger control and status block
`timescale 1ns/10ps
`default_nettype none
module dbgcs_top_tb import dbgcs_pkg::*;;
	localparam int RC = 4;
	logic clk = 0;
	logic rst_n = 0;
	logic op_v = 0;
	logic halt_m = 0;
	logic lock_n = 1;
	logic [7:0] op = 8'h11;
	logic rx_v, tx_r, tx_v, stall, spin, nop, srst_n;
	logic [7:0] rx_b, tx_b;
	int err_count = 0;
	int samples_checked = 0;
	int n, c0;
	// rows: write, halt mode, control read, status read
	logic [24:0] rows [6] = '{{8'h80, 1'b0, 8'h80, 8'h80}, {8'h40, 1'b1, 8'h40, 8'h40},
		{8'hf0, 1'b0, 8'hf0, 8'h80}, {8'h7e, 1'b0, 8'h70, 8'h00}, {8'h20, 1'b1, 8'h20, 8'h40},
		{8'h00, 1'b0, 8'h00, 8'h00}};
	// break rows: control, {nop,spin,stall}, ack, status
	logic [19:0] brows [6] = '{{8'h00, 3'b100, 1'b0, 8'h00}, {8'h20, 3'b100, 1'b0, 8'h00},
		{8'h40, 3'b001, 1'b0, 8'h80}, {8'h50, 3'b010, 1'b0, 8'h80}, {8'h60, 3'b001, 1'b1, 8'h80},
		{8'h70, 3'b010, 1'b1, 8'h80}};
	dbgcs_top #(.RESET_CYCLES(RC)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_rx_valid(rx_v), .i_rx_byte(rx_b),
		.i_tx_ready(tx_r), .i_opcode_valid(op_v), .i_opcode(op), .i_halt_mode(halt_m),
		.i_read_lock_opt_n(lock_n), .o_tx_valid(tx_v), .o_tx_byte(tx_b), .o_fetch_stall(stall),
		.o_break_spin(spin), .o_break_nop(nop), .o_sys_rst_n(srst_n));
	dbgcs_host_model host (.i_clk(clk), .i_tx_valid(tx_v), .i_tx_byte(tx_b), .o_rx_valid(rx_v),
		.o_rx_byte(rx_b), .o_tx_ready(tx_r));
	// 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end
	task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task print_verdict();
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// register read over the link, bounded wait for the answer
	task rd(input logic [7:0] cmd, output logic [7:0] v);
		c0 = host.got_cnt;
		host.send(cmd);
		host.idle();
		for (n = 0; n < 20 && host.got_cnt == c0; n++) @(posedge clk);
		#1 v = host.got;
		if (host.got_cnt == c0)
			v = 8'hxx;
	endtask
	// one break opcode from the core
	task break_opcode();
		@(posedge clk);
		#1 op_v = 1'b1;
		op = 8'h00;
		@(posedge clk);
		#1 op_v = 1'b0;
		op = 8'h11;
	endtask
	// watchdog
	initial begin
		#500000;
		err_count++;
		print_verdict();
	end
	initial begin
		logic [7:0] v;
		repeat (12) @(posedge clk);
		#1 rst_n = 1'b1;
		rd(DBGCS_CMD_RD_CTL, v);
		check("ctl reset", v, 8'h00);
		check("sys rst", {7'h0, srst_n}, 8'h01);
		// ordinary register rows
		foreach (rows[i]) begin
			halt_m = rows[i][16];
			host.wr_ctl(rows[i][24:17]);
			check("stall", {7'h0, stall}, {7'h0, rows[i][15]});
			rd(DBGCS_CMD_RD_CTL, v);
			check("ctl", v, rows[i][15:8]);
			rd(DBGCS_CMD_RD_STAT, v);
			check("stat", v, rows[i][7:0]);
		end
		// break opcode under six settings of control bits 6 to 4
		foreach (brows[i]) begin
			host.wr_ctl(brows[i][19:12]);
			c0 = host.got_cnt;
			break_opcode();
			check("brk", {5'h0, nop, spin, stall}, {5'h0, brows[i][11:9]});
			repeat (4) @(posedge clk);
			#1 check("ack cnt", 8'(host.got_cnt - c0), {7'h0, brows[i][8]});
			if (brows[i][8])
				check("ack chr", host.got, 8'hff);
			rd(DBGCS_CMD_RD_STAT, v);
			check("brk stat", v, brows[i][7:0]);
		end
		// reset and stop, then reset and go
		for (int j = 0; j < 2; j++) begin
			v = j ? 8'h41 : 8'h81;
			host.wr_ctl(v);
			c0 = 0;
			for (n = 0; n < 30; n++) begin
				@(posedge clk);
				#1 c0 += int'(!srst_n);
			end
			check("rst len", 8'(c0), 8'(RC));
			check("stall", {7'h0, stall}, {7'h0, v[7]});
			rd(DBGCS_CMD_RD_CTL, v);
			check("ctl", v, j ? 8'h40 : 8'h80);
		end
		// read lock: zero write to halt bit ignored
		lock_n = 1'b0;
		host.wr_ctl(8'h80);
		host.wr_ctl(8'h00);
		check("lock stall", {7'h0, stall}, 8'h01);
		rd(DBGCS_CMD_RD_STAT, v);
		check("lock stat", v, 8'ha0);
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		lock_n = 1'b1;
		check("rst stall", {7'h0, stall}, 8'h00);
		// slow host: answer stands, read while busy is dropped
		halt_m = 1'b1;
		host.set_ready(1'b0);
		c0 = host.got_cnt;
		host.send(DBGCS_CMD_RD_STAT);
		host.send(DBGCS_CMD_RD_CTL);
		host.idle();
		repeat (3) @(posedge clk);
		#1 check("held", {tx_v, tx_b[6:0]}, 8'hc0);
		host.set_ready(1'b1);
		repeat (4) @(posedge clk);
		#1 check("one ans", 8'(host.got_cnt - c0), 8'h01);
		check("ans", host.got, 8'h40);
		// an unknown command byte gets no answer
		c0 = host.got_cnt;
		host.send(8'h13);
		host.idle();
		repeat (3) @(posedge clk);
		#1 check("no ans", 8'(host.got_cnt - c0), 8'h00);
		print_verdict();
	end
endmodule
`default_nettype wire
